// *** design/tms_decode.sv ***
// Micro-instruction decoder and sequencer of the tape controller
//
// Behaviour
// - Mode 8: bits 1-3 pick a read enable, bit 4 sets it true/false
// - Read selects 0 and 1 enable low and high byte assembly
// - Read select 2 inverts the serial read bit when bit 4 is one
// - Read select 3 sets load or shift; mode 10 clears/loads/shifts read-in
// - Selects 4 and 5 steer CRC carry and CRC input routing
// - Selects 6 and 7 steer track error input and loopback
// - Mode 9 loads the shift enable mask; zero bits enable shifting
// - Mask bits 1 to 4 clock the write side elements
// - Mask bits 5 to 8 clock the read side elements
// - Mode 11 sets the read-after-write flag; 12 to 14 do nothing
// - Mode 15 enables set and clear subfunction decode together
// - Set code in bits 1-4; codes 0 and 4 do nothing
// - Set code 1 clears, 7 sets the direction line the CPU follows
// - Set codes 2,3,5,6,8,9: terminate clear, selects, interrupts
// - Set codes 10,11,14,15 prime write and read parity
// - Set codes 12 and 13 zero write CRC and write output
// - Clear code in bits 5-7 drives seven clear actions
// - Opcodes 4 and 5 load loop counters then step on
// - Opcode 6 loads the program address from bits 1-10
// - Opcode 7 saves address plus one in link, then branches
// - Opcode 8 samples one of 37 feedback bits into bit flag
// - Opcode 9 branches when selected flag is clear
// - Mode code taken from bits 9 to 12
// - Opcode 3 clocks each element whose mask bit is zero
`timescale 1ns/1ps

module tms_decode
   import tms_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [7:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // Control store
   output logic [9:0] micro_program_address_o,
   input wire logic [15:0] micro_word_i,
   // Feedback and flags
   input wire logic [37:1] feedback_bit_i,
   input wire logic [3:1] program_flag_i,
   input wire logic cpu_terminate_line_i,
   // Read data path enables (levels) and the one-cycle read-in strobe
   output logic low_byte_assemble_o,
   output logic high_byte_assemble_o,
   output logic read_invert_o,
   output logic read_in_shift_mode_o,
   output logic crc_carry_gate_o,
   output logic crc_read_route_o,
   output logic track_error_force_o,
   output logic loopback_o,
   output logic read_in_strobe_o,
   output logic read_after_write_flag_o,
   // Shift step strobes, one per mask bit
   output logic [7:0] shift_strobe_o,
   output logic [7:0] shift_enable_mask_o,
   // Subfunction pulses
   output logic [15:0] set_subfunction_o,
   output logic [7:0] clear_subfunction_o,
   // CPU transfer interface
   output logic direction_out_line_o,
   output logic terminate_flag_o,
   output logic program_interrupt_o,
   output logic transfer_interrupt_o,
   output logic bit_flag_o,
   output logic halted_o
);

   // ==========================================================
   // Helpers
   function automatic logic [7:0] onehot8(input logic [2:0] code);
      onehot8 = 8'h01 << code;
   endfunction

   // ==========================================================
   // Pin synchronisers
   logic [37:1] fb_meta_q, fb_sync_q;
   logic term_meta_q, term_sync_q;

   always_ff @(posedge clk_i) begin
      fb_meta_q <= feedback_bit_i;
      fb_sync_q <= fb_meta_q;
      term_meta_q <= cpu_terminate_line_i;
      term_sync_q <= term_meta_q;
   end

   // ==========================================================
   // State
   tms_state_type state_q, state_d;
   logic [9:0] addr_q, addr_d, link_q;
   logic [7:0] loop_one_q, read_ctrl_q, mask_q;
   logic [3:0] loop_two_q;
   logic bit_flag_q, raw_q, dir_q, term_q, pint_q, xint_q;
   logic [7:0] shift_q, clear_q;
   logic [15:0] set_q;
   logic read_in_q;

   // ==========================================================
   // Field decode
   wire logic running = (state_q == ST_RUN);
   wire logic [3:0] opcode = micro_word_i[15:OPC_LSB];
   wire logic [3:0] mode = micro_word_i[11:MODE_LSB];
   wire logic [9:0] target = micro_word_i[9:0];
   wire logic [9:0] addr_inc = addr_q + 10'h001;
   wire logic addr_fmt = running && (opcode <= OP_SHIFT_STEP);
   wire logic mode_read = addr_fmt && (mode == MODE_READ_CTRL);
   wire logic mode_mask = addr_fmt && (mode == MODE_SHIFT_MASK);
   wire logic mode_rin = addr_fmt && (mode == MODE_READ_IN);
   wire logic mode_raw = addr_fmt && (mode == MODE_RAW_SET);
   wire logic mode_sc = addr_fmt && (mode == MODE_SET_CLEAR);
   wire logic [2:0] read_sel = micro_word_i[2:0];
   wire logic read_val = micro_word_i[3];
   wire logic [3:0] set_code = micro_word_i[3:0];
   wire logic [2:0] clr_code = micro_word_i[6:4];
   // Codes 0 and 4 have no effect downstream; pulse masked off
   wire logic [15:0] set_hot = mode_sc ? ((16'h0001 << set_code)
      & 16'hFFEE) : 16'h0000;
   wire logic [7:0] clr_hot = mode_sc ? (onehot8(clr_code) & 8'hFE)
      : 8'h00;
   wire logic [7:0] read_hot = mode_read ? onehot8(read_sel) : 8'h00;
   wire logic [5:0] fb_sel = micro_word_i[FB_SEL_W-1:0];
   wire logic [37:0] fb_vec = {fb_sync_q, 1'b0};
   // Select 0 and selects above 37 sample a zero
   wire logic fb_pick = (fb_sel <= 6'(FB_COUNT)) ? fb_vec[fb_sel]
      : 1'b0;
   wire logic [3:0] flag_vec = {program_flag_i, bit_flag_q};
   wire logic flag_sel = flag_vec[micro_word_i[11:10]];
   wire logic [7:0] loop_one_dec = loop_one_q - 8'h01;
   wire logic [3:0] loop_two_dec = loop_two_q - 4'h1;

   // ==========================================================
   // Wishbone decode
   wire logic bus_req = cyc_i && stb_i && !ack_o;
   wire logic wr_ctl = bus_req && we_i && sel_i[0]
      && (adr_i == REG_CONTROL);
   wire logic sw_start = wr_ctl && dat_i[CTL_START];
   wire logic sw_clr_raw = wr_ctl && dat_i[CTL_CLR_RAW];
   wire logic sw_clr_pint = wr_ctl && dat_i[CTL_CLR_PINT];
   wire logic sw_clr_xint = wr_ctl && dat_i[CTL_CLR_XINT];
   wire logic [31:0] status_word = {15'h0000, xint_q, pint_q, term_q,
      dir_q, raw_q, bit_flag_q, !running, addr_q};
   wire logic [31:0] rd_word =
      (adr_i == REG_CONTROL) ? {31'h00000000, !running} :
      (adr_i == REG_STATUS) ? status_word :
      (adr_i == REG_MASKS) ? {16'h0000, mask_q, read_ctrl_q} :
      (adr_i == REG_LOOPS) ? {6'h00, link_q, 4'h0, loop_two_q,
         loop_one_q} : 32'h00000000;

   // ==========================================================
   // Sequencer next state
   always_comb begin
      state_d = state_q;
      addr_d = addr_q;
      case (state_q)
         ST_HALT: begin
            if (sw_start) begin
               state_d = ST_RUN;
               addr_d = START_ADDR;
            end
         end
         ST_RUN: begin
            case (opcode)
               OP_REST: begin
                  state_d = ST_HALT;
                  addr_d = START_ADDR;
               end
               OP_RETURN: addr_d = link_q;
               OP_BRANCH, OP_CALL: addr_d = target;
               OP_BRANCH_FLAG_CLEAR:
                  addr_d = flag_sel ? addr_inc : target;
               OP_BRANCH_FLAG_SET:
                  addr_d = flag_sel ? target : addr_inc;
               OP_LOOP_ONE:
                  addr_d = (loop_one_dec != 8'h00) ? target : addr_inc;
               OP_LOOP_TWO:
                  addr_d = (loop_two_dec != 4'h0) ? target : addr_inc;
               default: addr_d = addr_inc;
            endcase
         end
         default: begin
            state_d = ST_HALT;
            addr_d = START_ADDR;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_q <= ST_HALT;
         addr_q <= START_ADDR;
      end else begin
         state_q <= state_d;
         addr_q <= addr_d;
      end
   end

   // ==========================================================
   // Link register and loop counters
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         link_q <= START_ADDR;
         loop_one_q <= 8'h00;
         loop_two_q <= 4'h0;
      end else if (running) begin
         if (opcode == OP_CALL)
            link_q <= addr_inc;
         if (opcode == OP_LOAD_LOOP_ONE)
            loop_one_q <= micro_word_i[7:0];
         else if (opcode == OP_LOOP_ONE)
            loop_one_q <= loop_one_dec;
         if (opcode == OP_LOAD_LOOP_TWO)
            loop_two_q <= micro_word_i[3:0];
         else if (opcode == OP_LOOP_TWO)
            loop_two_q <= loop_two_dec;
      end
   end

   // ==========================================================
   // Read control register and shift enable mask
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         read_ctrl_q <= READ_CTRL_RST;
         mask_q <= SHIFT_MASK_RST;
      end else begin
         // Only the selected enable moves
         read_ctrl_q <= (read_ctrl_q & ~read_hot)
            | (read_val ? read_hot : 8'h00);
         if (mode_mask)
            mask_q <= micro_word_i[7:0];
      end
   end

   // ==========================================================
   // Flags; a hardware set wins over a same-cycle clear
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         bit_flag_q <= 1'b0;
         raw_q <= 1'b0;
         dir_q <= 1'b0;
         term_q <= 1'b0;
         pint_q <= 1'b0;
         xint_q <= 1'b0;
      end else begin
         if (running && opcode == OP_SAMPLE)
            bit_flag_q <= fb_pick;
         raw_q <= mode_raw || (raw_q && !sw_clr_raw);
         if (set_hot[SET_DIR_TO_CPU])
            dir_q <= 1'b1;
         else if (set_hot[SET_DIR_TO_CTRL])
            dir_q <= 1'b0;
         term_q <= term_sync_q
            || (term_q && !set_hot[SET_CLR_TERM]);
         pint_q <= set_hot[SET_PROG_INT]
            || (pint_q && !sw_clr_pint);
         xint_q <= set_hot[SET_XFER_INT]
            || (xint_q && !sw_clr_xint);
      end
   end

   // ==========================================================
   // Registered strobes toward the data path
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         shift_q <= 8'h00;
         set_q <= 16'h0000;
         clear_q <= 8'h00;
         read_in_q <= 1'b0;
      end else begin
         // Zero mask bit means the element is clocked
         shift_q <= (running && opcode == OP_SHIFT_STEP) ? ~mask_q
            : 8'h00;
         set_q <= set_hot;
         clear_q <= clr_hot;
         read_in_q <= mode_rin;
      end
   end

   // ==========================================================
   // Wishbone answer, one wait state
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
         dat_o <= 32'h00000000;
      end else begin
         ack_o <= bus_req;
         dat_o <= bus_req ? rd_word : 32'h00000000;
      end
   end

   // ==========================================================
   // Outputs
   assign micro_program_address_o = addr_q;
   assign low_byte_assemble_o = read_ctrl_q[0];
   assign high_byte_assemble_o = read_ctrl_q[1];
   assign read_invert_o = read_ctrl_q[2];
   assign read_in_shift_mode_o = read_ctrl_q[READ_IN_SEL];
   assign crc_carry_gate_o = read_ctrl_q[4];
   assign crc_read_route_o = read_ctrl_q[5];
   assign track_error_force_o = read_ctrl_q[6];
   assign loopback_o = read_ctrl_q[7];
   assign read_in_strobe_o = read_in_q;
   assign read_after_write_flag_o = raw_q;
   assign shift_strobe_o = shift_q;
   assign shift_enable_mask_o = mask_q;
   assign set_subfunction_o = set_q;
   assign clear_subfunction_o = clear_q;
   assign direction_out_line_o = dir_q;
   assign terminate_flag_o = term_q;
   assign program_interrupt_o = pint_q;
   assign transfer_interrupt_o = xint_q;
   assign bit_flag_o = bit_flag_q;
   assign halted_o = !running;

endmodule // tms_decode

// *** design/tms_pkg.sv ***
// Constants shared by the tape micro-sequencer decoder
package tms_pkg;

   // ==========================================================
   // Instruction word layout (micro bit n is word bit n-1)
   localparam int WORD_W = 16;
   localparam int ADDR_W = 10;
   localparam int OPC_LSB = 12;
   localparam int MODE_LSB = 8;
   localparam int FB_COUNT = 37;
   localparam int FB_SEL_W = 6;

   // ==========================================================
   // Primary function codes
   localparam logic [3:0] OP_REST = 4'h0;
   localparam logic [3:0] OP_CONT = 4'h1;
   localparam logic [3:0] OP_RETURN = 4'h2;
   localparam logic [3:0] OP_SHIFT_STEP = 4'h3;
   localparam logic [3:0] OP_LOAD_LOOP_ONE = 4'h4;
   localparam logic [3:0] OP_LOAD_LOOP_TWO = 4'h5;
   localparam logic [3:0] OP_BRANCH = 4'h6;
   localparam logic [3:0] OP_CALL = 4'h7;
   localparam logic [3:0] OP_SAMPLE = 4'h8;
   localparam logic [3:0] OP_BRANCH_FLAG_CLEAR = 4'h9;
   localparam logic [3:0] OP_BRANCH_FLAG_SET = 4'hA;
   localparam logic [3:0] OP_LOOP_ONE = 4'hC;
   localparam logic [3:0] OP_LOOP_TWO = 4'hD;

   // ==========================================================
   // Mode subfunction codes
   localparam logic [3:0] MODE_READ_CTRL = 4'h8;
   localparam logic [3:0] MODE_SHIFT_MASK = 4'h9;
   localparam logic [3:0] MODE_READ_IN = 4'hA;
   localparam logic [3:0] MODE_RAW_SET = 4'hB;
   localparam logic [3:0] MODE_SET_CLEAR = 4'hF;

   // ==========================================================
   // Set and clear subfunction codes with level effects
   localparam logic [3:0] SET_DIR_TO_CTRL = 4'h1;
   localparam logic [3:0] SET_CLR_TERM = 4'h2;
   localparam logic [3:0] SET_DIR_TO_CPU = 4'h7;
   localparam logic [3:0] SET_PROG_INT = 4'h8;
   localparam logic [3:0] SET_XFER_INT = 4'h9;
   localparam int READ_IN_SEL = 3;

   // ==========================================================
   // Sequencer reset state
   localparam logic [9:0] START_ADDR = 10'h000;
   localparam logic [7:0] READ_CTRL_RST = 8'h00;
   localparam logic [7:0] SHIFT_MASK_RST = 8'hFF;

   // ==========================================================
   // Wishbone register map (byte addresses)
   localparam logic [7:0] REG_CONTROL = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_MASKS = 8'h08;
   localparam logic [7:0] REG_LOOPS = 8'h0C;
   localparam int CTL_START = 0;
   localparam int CTL_CLR_RAW = 1;
   localparam int CTL_CLR_PINT = 2;
   localparam int CTL_CLR_XINT = 3;

   typedef enum logic [1:0] {
      ST_HALT = 2'b01,
      ST_RUN = 2'b10
   } tms_state_type;

endpackage

// *** verif/tms_store_model.sv ***
// Control store and CPU direction follower beside the sequencer
`timescale 1ns/1ps
module tms_store_model
   import tms_pkg::*;
(
   input wire logic clk_i,
   input wire logic [9:0] addr_i,
   output logic [15:0] word_o,
   input wire logic load_i,
   input wire logic [9:0] load_addr_i,
   input wire logic [15:0] load_data_i,
   input wire logic direction_i,
   output logic cpu_dir_o
);
   // ==========================================================
   // Store, fetched in the same cycle
   logic [15:0] mem_q [0:1023];
   assign word_o = mem_q[addr_i];
   always @(posedge clk_i) begin
      if (load_i) begin
         mem_q[load_addr_i] <= load_data_i;
      end
      cpu_dir_o <= direction_i;
   end
endmodule // tms_store_model

// *** verif/tms_decode_assertions.sv ***
// Concurrent checks on the sequencer ports
`timescale 1ns/1ps
module tms_decode_assertions
   import tms_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [9:0] micro_program_address_o,
   input wire logic [15:0] micro_word_i,
   input wire logic read_after_write_flag_o,
   input wire logic [7:0] shift_strobe_o,
   input wire logic [7:0] shift_enable_mask_o,
   input wire logic [15:0] set_subfunction_o,
   input wire logic [7:0] clear_subfunction_o,
   input wire logic direction_out_line_o,
   input wire logic bit_flag_o,
   input wire logic halted_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // ==========================================================
   // Decode of the executing word
   wire run_w = !halted_o;
   wire [3:0] op_w = micro_word_i[15:12];
   wire [3:0] md_w = micro_word_i[11:8];
   wire mok_w = run_w && (op_w <= OP_SHIFT_STEP);
   logic [15:0] w_q;
   always_ff @(posedge clk_i) begin
      w_q <= micro_word_i;
   end
   // ==========================================================
   // Properties
   a_mask_load: assert property (mok_w && md_w == MODE_SHIFT_MASK
      |=> shift_enable_mask_o == w_q[7:0]) else $error("mask load");
   a_shift_strobe: assert property (run_w && op_w == OP_SHIFT_STEP
      && md_w != MODE_SHIFT_MASK |=> shift_strobe_o == ~shift_enable_mask_o)
      else $error("shift strobe");
   a_strobe_idle: assert property (!(run_w && op_w == OP_SHIFT_STEP)
      |=> shift_strobe_o == 8'h00) else $error("stray strobe");
   a_raw_set: assert property (mok_w && md_w == MODE_RAW_SET
      |=> read_after_write_flag_o) else $error("raw flag");
   a_set_pulse: assert property (mok_w && md_w == MODE_SET_CLEAR
      |=> set_subfunction_o == ((w_q[3:0] == 4'h0 || w_q[3:0] == 4'h4)
      ? 16'h0000 : (16'h0001 << w_q[3:0]))) else $error("set pulse");
   a_clear_pulse: assert property (mok_w && md_w == MODE_SET_CLEAR
      |=> clear_subfunction_o == ((w_q[6:4] == 3'h0) ? 8'h00
      : (8'h01 << w_q[6:4]))) else $error("clear pulse");
   a_sub_quiet: assert property (!(mok_w && md_w == MODE_SET_CLEAR)
      |=> set_subfunction_o == 16'h0000 && clear_subfunction_o == 8'h00)
      else $error("stray pulse");
   a_dir_line: assert property (mok_w && md_w == MODE_SET_CLEAR
      && (micro_word_i[3:0] == 4'h1 || micro_word_i[3:0] == 4'h7)
      |=> direction_out_line_o == (w_q[3:0] == 4'h7)) else $error("dir");
   a_jump_addr: assert property (run_w && op_w[3:1] == 3'h3
      |=> micro_program_address_o == w_q[9:0]) else $error("jump");
   a_step_on: assert property (run_w && (op_w == 4'h4
      || op_w == 4'h5 || op_w == 4'h8) |=> micro_program_address_o ==
      $past(micro_program_address_o) + 10'h001) else $error("step on");
   a_flag_clear: assert property (run_w && op_w == 4'h9
      && micro_word_i[11:10] == 2'b00 |=> micro_program_address_o ==
      ($past(bit_flag_o) ? $past(micro_program_address_o) + 10'h001
      : w_q[9:0])) else $error("flag branch");
   c_call: cover property (run_w && op_w == OP_CALL);
   c_flag_clear: cover property (run_w && op_w == OP_BRANCH_FLAG_CLEAR);
   c_set_clear: cover property (mok_w && md_w == MODE_SET_CLEAR);
endmodule // tms_decode_assertions

bind tms_decode tms_decode_assertions i_chk (.clk_i, .rst_i,
   .micro_program_address_o, .micro_word_i, .read_after_write_flag_o,
   .shift_strobe_o, .shift_enable_mask_o, .set_subfunction_o,
   .clear_subfunction_o, .direction_out_line_o, .bit_flag_o, .halted_o);

// *** verif/test_tms_decode.sv ***
// Self-checking bench for the tape micro-sequencer decoder
`timescale 1ns/1ps
module test_tms_decode;
   import tms_pkg::*;
   logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, halted_o, ld_q, cdir;
   logic cpu_terminate_line_i, direction_out_line_o;
   logic [7:0] adr_i, mask, v, s;
   logic [3:0] sel_i, q;
   logic [31:0] dat_i, dat_o, rd;
   logic [9:0] micro_program_address_o, ld_a;
   logic [15:0] micro_word_i, ld_d;
   logic [15:0] prog [0:21];
   logic [37:1] fb, fbv;
   logic [3:1] pf;
   int mismatches, n_checks, i, r;
   tms_decode i_dut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i,
      .dat_i, .dat_o, .ack_o, .micro_program_address_o, .micro_word_i,
      .feedback_bit_i(fb), .program_flag_i(pf), .cpu_terminate_line_i,
      .low_byte_assemble_o(), .high_byte_assemble_o(), .read_invert_o(),
      .read_in_shift_mode_o(), .crc_carry_gate_o(), .crc_read_route_o(),
      .track_error_force_o(), .loopback_o(), .read_in_strobe_o(),
      .read_after_write_flag_o(), .shift_strobe_o(), .shift_enable_mask_o(),
      .set_subfunction_o(), .clear_subfunction_o(), .direction_out_line_o,
      .terminate_flag_o(), .program_interrupt_o(), .transfer_interrupt_o(),
      .bit_flag_o(), .halted_o);
   tms_store_model i_store (.clk_i, .addr_i(micro_program_address_o),
      .word_o(micro_word_i), .load_i(ld_q), .load_addr_i(ld_a),
      .load_data_i(ld_d), .direction_i(direction_out_line_o),
      .cpu_dir_o(cdir));
   // ==========================================================
   // Tasks
   task automatic chk(input string what, input logic [31:0] e,
      input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      cyc_i <= 1'b1; stb_i <= 1'b1; we_i <= w; adr_i <= a; dat_i <= d;
      sel_i <= 4'hF;
      for (k = 0; k < 50; k++) begin
         @(posedge clk_i);
         if (ack_o === 1'b1) break;
      end
      if (k == 50) mismatches++;
      rd = dat_o;
      cyc_i <= 1'b0; stb_i <= 1'b0; we_i <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic wait_halt(input logic lvl);
      int k;
      for (k = 0; k < 200 && halted_o !== lvl; k++) @(posedge clk_i);
      if (k == 200) mismatches++;
   endtask
   task automatic complete_run();
      $display("mismatches %0d n_checks %0d", mismatches, n_checks);
      if (mismatches == 0 && n_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // ==========================================================
   // Clock, watchdog sized well past two short programs
   initial begin
      clk_i = 1'b0;
      forever #2 clk_i = ~clk_i;
   end
   initial begin
      repeat (5000) @(posedge clk_i);
      mismatches++;
      complete_run();
   end
   // ==========================================================
   // Main sequence
   initial begin
      rst_i = 1'b1; cyc_i = 1'b0; stb_i = 1'b0; we_i = 1'b0; adr_i = 8'h00;
      sel_i = 4'h0; dat_i = 32'h0; fb = '0; pf = 3'h0; ld_q = 1'b0;
      cpu_terminate_line_i = 1'b0; ld_a = 10'h000; ld_d = 16'h0000;
      mismatches = 0; n_checks = 0;
      void'($urandom(9));
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      wb(1'b0, REG_STATUS, 32'h0); chk("status", 32'h00000400, rd);
      wb(1'b0, REG_MASKS, 32'h0); chk("masks", 32'h0000FF00, rd);
      wb(1'b0, 8'h10, 32'h0); chk("unmapped", 32'h0, rd);
      for (r = 0; r < 2; r++) begin
         mask = $urandom; v = $urandom; q = $urandom;
         s = (r == 0) ? 8'd37 : 8'd1 + 8'($urandom % 37);
         fbv = 37'({$urandom, $urandom});
         fbv[s] = (r == 0);
         fb <= fbv; pf <= $urandom;
         // Terminate line held high in the second pass only
         cpu_terminate_line_i <= (r == 1);
         for (i = 0; i < 22; i++) prog[i] = 16'h0000;
         prog[0] = 16'h1808; prog[1] = {8'h19, mask}; prog[2] = 16'h3000;
         prog[3] = {8'h40, v}; prog[4] = {12'h500, q}; prog[5] = 16'h700A;
         prog[10] = 16'h1F37; prog[11] = {8'h80, s}; prog[12] = 16'h9014;
         prog[13] = 16'h0B00; prog[20] = 16'h6015;
         ld_q <= 1'b1;
         for (i = 0; i < 22; i++) begin
            ld_a <= i[9:0]; ld_d <= prog[i];
            @(posedge clk_i);
         end
         ld_q <= 1'b0;
         wb(1'b1, REG_CONTROL, 32'h2);
         wb(1'b1, REG_CONTROL, 32'h1);
         wait_halt(1'b0);
         wait_halt(1'b1);
         wb(1'b0, REG_STATUS, 32'h0);
         rd = rd ^ {17'h0, r == 1, 1'b0, r == 0, r == 0, 11'h0};
         chk("status", 32'h2400, rd);
         wb(1'b0, REG_MASKS, 32'h0);
         chk("masks", {16'h0, mask, 8'h01}, rd);
         wb(1'b0, REG_LOOPS, 32'h0);
         chk("loops", {6'h0, 10'd6, 4'h0, q, v}, rd);
         chk("cpu_dir", 32'h1, {31'h0, cdir});
      end
      complete_run();
   end
endmodule // test_tms_decode
